// >>> src/hsif_status_irq.sv
// Purpose: status bits, sticky change flags, masks and interrupt of the haptic driver
// Assumes: condition inputs are asynchronous levels; tune done is a level pulse at least one clock period wide
// Notes: flags clear by writing 1 to the clear registers; a set beats a clear
//
// Summary of operation
// - bit7 shows supply below disable threshold, locks
// - bit6 shows positive low-side overcurrent, locks
// - bit5 shows negative low-side overcurrent, locks
// - bit4 shows positive high-side overcurrent, locks
// - bit3 shows negative high-side overcurrent, locks
// - bit2 shows overtemperature, locks driver
// - bit1 shows driver clock enabled
// - bit0 shows resonance frequency locked
// - summary bit set while any fault locks
// - converter bit shows conversion running
// - each status0 change sets matching flag
// - event bit3 sets on auto-tune completion
// - event bit2 sets on timeout, locks
// - event bit1 sets on undervoltage, locks
// - event bit0 sets on summary change
// - mask bit 1 passes, 0 blocks flag
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module hsif_status_irq
  import hsif_pkg::*;
(
  input wire logic i_clk, // 10 MHz system clock
  input wire logic i_sys_rst, // synchronous, active high
  input wire hsif_cond_t i_cond, // raw asynchronous conditions
  input wire logic [7:0] i_addr, // register index
  input wire logic [7:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [7:0] o_rdata, // read data, cycle after read
  output logic o_irq, // level interrupt
  output logic o_driver_lock // driver locked and disabled
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  hsif_state_t st; // registered state
  hsif_state_t next_st; // next state
  logic [7:0] next_status0; // status0 from synchronised inputs
  logic next_summary; // summary fault from synchronised inputs
  logic [HSIF_EVENT_BITS-1:0] ev_set; // event flag set terms
  logic [7:0] fc_set; // change flag set terms

  // write decode shared by several registers
  function automatic logic hit(input logic wr, input logic [7:0] a, input logic [7:0] r);
    hit = wr && (a == r);
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // two-stage synchroniser on every raw condition
    next_st.sync1 = i_cond;
    next_st.sync2 = st.sync1;
    // status0 fields from the second stage only
    next_status0[HSIF_POS_SUPPLY_DISABLE] = st.sync2.supply_disable_fault;
    next_status0[HSIF_POS_POS_LOW_OC] = st.sync2.pos_low_side_overcurrent;
    next_status0[HSIF_POS_NEG_LOW_OC] = st.sync2.neg_low_side_overcurrent;
    next_status0[HSIF_POS_POS_HIGH_OC] = st.sync2.pos_high_side_overcurrent;
    next_status0[HSIF_POS_NEG_HIGH_OC] = st.sync2.neg_high_side_overcurrent;
    next_status0[HSIF_POS_THERMAL] = st.sync2.thermal_fault;
    next_status0[HSIF_POS_CLOCK_ON] = st.sync2.driver_clock_on;
    next_status0[HSIF_POS_RES_LOCK] = st.sync2.resonance_locked;
    // any locking fault, including timeout and undervoltage
    next_summary = (|next_status0[HSIF_POS_SUPPLY_DISABLE:HSIF_POS_THERMAL])
                   || st.sync2.supply_undervoltage || st.sync2.vibration_timeout;
    next_st.status0 = next_status0;
    next_st.summary_fault = next_summary;
    next_st.converter_running = st.sync2.converter_running;
    next_st.driver_lock = next_summary;
    next_st.uvlo_q = st.sync2.supply_undervoltage;
    next_st.timeout_q = st.sync2.vibration_timeout;
    next_st.tune_q = st.sync2.tune_done;
    next_st.primed = 1'b1;
    // change detection is held off for the first cycle so reset values do not flag
    fc_set = st.primed ? (next_status0 ^ st.status0) : 8'h00;
    ev_set = '0;
    if (st.primed) begin
      ev_set[HSIF_POS_TUNE_DONE] = st.sync2.tune_done && !st.tune_q;
      ev_set[HSIF_POS_TIMEOUT] = st.sync2.vibration_timeout && !st.timeout_q;
      ev_set[HSIF_POS_UVLO] = st.sync2.supply_undervoltage && !st.uvlo_q;
      ev_set[HSIF_POS_SUM_CHANGE] = next_summary ^ st.summary_fault;
    end
    // sticky flags: clear by write-one, set wins over clear
    next_st.fault_change_flags = fc_set | (st.fault_change_flags &
      ~(hit(i_wr, i_addr, HSIF_ADDR_FAULT_CHANGE_CLEAR) ? i_wdata : 8'h00));
    next_st.event_flags = ev_set | (st.event_flags &
      ~(hit(i_wr, i_addr, HSIF_ADDR_EVENT_CLEAR) ? i_wdata[HSIF_EVENT_BITS-1:0]
        : HSIF_RST_EVENT));
    // mask registers
    if (hit(i_wr, i_addr, HSIF_ADDR_FAULT_CHANGE_MASK)) begin
      next_st.fault_change_mask = i_wdata;
    end
    if (hit(i_wr, i_addr, HSIF_ADDR_EVENT_MASK)) begin
      next_st.event_mask = i_wdata[HSIF_EVENT_BITS-1:0];
    end
    // interrupt from unmasked flags as they will stand
    next_st.irq = |(next_st.fault_change_flags & next_st.fault_change_mask)
                  || |(next_st.event_flags & next_st.event_mask);
    // read mux, unmapped reads give zero
    next_st.rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        HSIF_ADDR_DRIVER_FAULT_STATUS: next_st.rdata = st.status0;
        HSIF_ADDR_SUMMARY_FAULT_STATUS: next_st.rdata = {7'h00, st.summary_fault};
        HSIF_ADDR_CONVERTER_BUSY_STATUS: next_st.rdata = {6'h00, st.converter_running, 1'b0};
        HSIF_ADDR_FAULT_CHANGE_FLAGS: next_st.rdata = st.fault_change_flags;
        HSIF_ADDR_EVENT_FLAGS: next_st.rdata = {4'h0, st.event_flags};
        HSIF_ADDR_FAULT_CHANGE_MASK: next_st.rdata = st.fault_change_mask;
        HSIF_ADDR_EVENT_MASK: next_st.rdata = {4'h0, st.event_mask};
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flip-flops
  assign o_rdata = st.rdata;
  assign o_irq = st.irq;
  assign o_driver_lock = st.driver_lock;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_supply_bit;
    @(posedge i_clk) disable iff (i_sys_rst)
    $past(st.sync2.supply_disable_fault) |-> st.status0[HSIF_POS_SUPPLY_DISABLE];
  endproperty
  a_supply_bit: assert property (p_supply_bit)
    else $error("supply bit not set");

  // thermal bit follows the synchronised level one edge later
  property p_thermal_bit;
    @(posedge i_clk) disable iff (i_sys_rst)
    st.primed |-> st.status0[HSIF_POS_THERMAL] == $past(st.sync2.thermal_fault);
  endproperty
  a_thermal_bit: assert property (p_thermal_bit)
    else $error("thermal bit wrong");

  // clock-on bit follows the synchronised level one edge later
  property p_clock_bit;
    @(posedge i_clk) disable iff (i_sys_rst)
    st.primed |-> st.status0[HSIF_POS_CLOCK_ON] == $past(st.sync2.driver_clock_on);
  endproperty
  a_clock_bit: assert property (p_clock_bit)
    else $error("clock bit wrong");

  // resonance lock bit follows the synchronised level one edge later
  property p_res_lock_bit;
    @(posedge i_clk) disable iff (i_sys_rst)
    st.primed |-> st.status0[HSIF_POS_RES_LOCK] == $past(st.sync2.resonance_locked);
  endproperty
  a_res_lock_bit: assert property (p_res_lock_bit)
    else $error("resonance lock bit wrong");

  // converter busy bit follows the synchronised level one edge later
  property p_conv_bit;
    @(posedge i_clk) disable iff (i_sys_rst)
    st.primed |-> st.converter_running == $past(st.sync2.converter_running);
  endproperty
  a_conv_bit: assert property (p_conv_bit)
    else $error("converter bit wrong");

  // summary is exactly the or of every locking fault, high and low
  property p_summary;
    @(posedge i_clk) disable iff (i_sys_rst)
    st.primed |-> st.summary_fault == ((|st.status0[7:2])
      || $past(st.sync2.supply_undervoltage) || $past(st.sync2.vibration_timeout));
  endproperty
  a_summary: assert property (p_summary)
    else $error("summary bit wrong");

  // the lock output never parts from the summary fault
  property p_lock_out;
    @(posedge i_clk) disable iff (i_sys_rst)
    o_driver_lock == st.summary_fault;
  endproperty
  a_lock_out: assert property (p_lock_out)
    else $error("lock output wrong");

  property p_oc_bits;
    @(posedge i_clk) disable iff (i_sys_rst)
    st.primed |-> st.status0[6:3] == {$past(st.sync2.pos_low_side_overcurrent),
      $past(st.sync2.neg_low_side_overcurrent), $past(st.sync2.pos_high_side_overcurrent),
      $past(st.sync2.neg_high_side_overcurrent)};
  endproperty
  a_oc_bits: assert property (p_oc_bits)
    else $error("overcurrent bits wrong");

  property p_lock;
    @(posedge i_clk) disable iff (i_sys_rst)
    (|st.status0[7:2]) |-> (st.summary_fault && o_driver_lock);
  endproperty
  a_lock: assert property (p_lock)
    else $error("fault without lock");

  property p_change;
    @(posedge i_clk) disable iff (i_sys_rst)
    (st.primed && $past(st.primed) && st.status0 != $past(st.status0))
      |-> ((st.status0 ^ $past(st.status0)) & ~st.fault_change_flags) == 8'h00;
  endproperty
  a_change: assert property (p_change)
    else $error("change flag missed");

  property p_sum_change;
    @(posedge i_clk) disable iff (i_sys_rst)
    ($past(st.primed) && $changed(st.summary_fault)) |-> st.event_flags[HSIF_POS_SUM_CHANGE];
  endproperty
  a_sum_change: assert property (p_sum_change)
    else $error("summary change missed");

  property p_timeout;
    @(posedge i_clk) disable iff (i_sys_rst)
    $rose(st.timeout_q) && $past(st.primed) |-> st.event_flags[HSIF_POS_TIMEOUT];
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout flag missed");

  // ----------------------------------------------------------------
  // event flag, change flag and interrupt assertions
  // ----------------------------------------------------------------

  // undervoltage rise sets its event flag at the same edge
  property p_uvlo;
    @(posedge i_clk) disable iff (i_sys_rst)
    $rose(st.uvlo_q) && $past(st.primed) |-> st.event_flags[HSIF_POS_UVLO];
  endproperty
  a_uvlo: assert property (p_uvlo)
    else $error("undervoltage flag missed");

  // tune completion rise sets its event flag at the same edge
  property p_tune;
    @(posedge i_clk) disable iff (i_sys_rst)
    $rose(st.tune_q) && $past(st.primed) |-> st.event_flags[HSIF_POS_TUNE_DONE];
  endproperty
  a_tune: assert property (p_tune)
    else $error("tune flag missed");

  property p_sticky;
    @(posedge i_clk) disable iff (i_sys_rst)
    (st.event_flags[HSIF_POS_TUNE_DONE] && !(i_wr && i_addr == HSIF_ADDR_EVENT_CLEAR))
      |=> st.event_flags[HSIF_POS_TUNE_DONE];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag dropped without clear");

  // a change that meets a clear in the same cycle still leaves its flag set
  property p_fc_set_wins;
    @(posedge i_clk) disable iff (i_sys_rst)
    (|fc_set) |=> (st.fault_change_flags & $past(fc_set)) == $past(fc_set);
  endproperty
  a_fc_set_wins: assert property (p_fc_set_wins)
    else $error("change flag lost to clear");

  // an event that meets a clear in the same cycle still leaves its flag set
  property p_ev_set_wins;
    @(posedge i_clk) disable iff (i_sys_rst)
    (|ev_set) |=> (st.event_flags & $past(ev_set)) == $past(ev_set);
  endproperty
  a_ev_set_wins: assert property (p_ev_set_wins)
    else $error("event flag lost to clear");

  // write-one clear drops every chosen change flag not being set again
  property p_fc_clear;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_wr && i_addr == HSIF_ADDR_FAULT_CHANGE_CLEAR)
      |=> (st.fault_change_flags & $past(i_wdata) & ~$past(fc_set)) == 8'h00;
  endproperty
  a_fc_clear: assert property (p_fc_clear)
    else $error("change flag not cleared");

  // write-one clear drops every chosen event flag not being set again
  property p_ev_clear;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_wr && i_addr == HSIF_ADDR_EVENT_CLEAR)
      |=> ({4'h0, st.event_flags} & $past(i_wdata) & ~{4'h0, $past(ev_set)}) == 8'h00;
  endproperty
  a_ev_clear: assert property (p_ev_clear)
    else $error("event flag not cleared");

  // change flags never drop without a write to their clear register
  property p_fc_sticky;
    @(posedge i_clk) disable iff (i_sys_rst)
    !(i_wr && i_addr == HSIF_ADDR_FAULT_CHANGE_CLEAR)
      |=> (~st.fault_change_flags & $past(st.fault_change_flags)) == 8'h00;
  endproperty
  a_fc_sticky: assert property (p_fc_sticky)
    else $error("change flag dropped without clear");

  property p_irq;
    @(posedge i_clk) disable iff (i_sys_rst)
    o_irq == (|(st.fault_change_flags & st.fault_change_mask)
              || |(st.event_flags & st.event_mask));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt mismatch");

  // ----------------------------------------------------------------
  // mask and register port assertions
  // ----------------------------------------------------------------

  // with every mask at zero the interrupt stays low
  property p_masked_quiet;
    @(posedge i_clk) disable iff (i_sys_rst)
    (st.fault_change_mask == 8'h00 && st.event_mask == HSIF_RST_EVENT) |-> !o_irq;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet)
    else $error("masked flag raised interrupt");

  // change mask write lands at the next edge
  property p_fc_mask_write;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_wr && i_addr == HSIF_ADDR_FAULT_CHANGE_MASK)
      |=> st.fault_change_mask == $past(i_wdata);
  endproperty
  a_fc_mask_write: assert property (p_fc_mask_write)
    else $error("change mask write lost");

  // event mask write lands at the next edge
  property p_ev_mask_write;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_wr && i_addr == HSIF_ADDR_EVENT_MASK)
      |=> st.event_mask == $past(i_wdata[HSIF_EVENT_BITS-1:0]);
  endproperty
  a_ev_mask_write: assert property (p_ev_mask_write)
    else $error("event mask write lost");

  property p_read;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_rd && i_addr == HSIF_ADDR_CONVERTER_BUSY_STATUS)
      |=> o_rdata == {6'h00, $past(st.converter_running), 1'b0};
  endproperty
  a_read: assert property (p_read)
    else $error("converter read wrong");

  // driver fault status read returns the register one cycle later
  property p_read_status;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_rd && i_addr == HSIF_ADDR_DRIVER_FAULT_STATUS)
      |=> o_rdata == $past(st.status0);
  endproperty
  a_read_status: assert property (p_read_status)
    else $error("status read wrong");

  // summary read returns the fault bit in bit zero only
  property p_read_summary;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_rd && i_addr == HSIF_ADDR_SUMMARY_FAULT_STATUS)
      |=> o_rdata == {7'h00, $past(st.summary_fault)};
  endproperty
  a_read_summary: assert property (p_read_summary)
    else $error("summary read wrong");

  // change flag read returns the sticky flags one cycle later
  property p_read_flags;
    @(posedge i_clk) disable iff (i_sys_rst)
    (i_rd && i_addr == HSIF_ADDR_FAULT_CHANGE_FLAGS)
      |=> o_rdata == $past(st.fault_change_flags);
  endproperty
  a_read_flags: assert property (p_read_flags)
    else $error("change flag read wrong");

endmodule

`default_nettype wire

// >>> src/hsif_pkg.sv
// Purpose: shared constants and types for the haptic status and interrupt-flag block
// Assumes: 8-bit registers on a plain strobe port, one clock
// Notes: offsets are register indices on the plain port
package hsif_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] HSIF_ADDR_DRIVER_FAULT_STATUS = 8'h00;
  localparam logic [7:0] HSIF_ADDR_SUMMARY_FAULT_STATUS = 8'h01;
  localparam logic [7:0] HSIF_ADDR_CONVERTER_BUSY_STATUS = 8'h02;
  localparam logic [7:0] HSIF_ADDR_FAULT_CHANGE_FLAGS = 8'h03;
  localparam logic [7:0] HSIF_ADDR_EVENT_FLAGS = 8'h04;
  localparam logic [7:0] HSIF_ADDR_FAULT_CHANGE_MASK = 8'h06;
  localparam logic [7:0] HSIF_ADDR_EVENT_MASK = 8'h07;
  localparam logic [7:0] HSIF_ADDR_FAULT_CHANGE_CLEAR = 8'h10;
  localparam logic [7:0] HSIF_ADDR_EVENT_CLEAR = 8'h11;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int HSIF_POS_SUPPLY_DISABLE = 7;
  localparam int HSIF_POS_POS_LOW_OC = 6;
  localparam int HSIF_POS_NEG_LOW_OC = 5;
  localparam int HSIF_POS_POS_HIGH_OC = 4;
  localparam int HSIF_POS_NEG_HIGH_OC = 3;
  localparam int HSIF_POS_THERMAL = 2;
  localparam int HSIF_POS_CLOCK_ON = 1;
  localparam int HSIF_POS_RES_LOCK = 0;
  localparam int HSIF_POS_SUMMARY = 0;
  localparam int HSIF_POS_CONV_RUN = 1;
  localparam int HSIF_POS_TUNE_DONE = 3;
  localparam int HSIF_POS_TIMEOUT = 2;
  localparam int HSIF_POS_UVLO = 1;
  localparam int HSIF_POS_SUM_CHANGE = 0;
  localparam int HSIF_EVENT_BITS = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] HSIF_RST_BYTE = 8'h00;
  localparam logic [HSIF_EVENT_BITS-1:0] HSIF_RST_EVENT = 4'h0;

  // raw condition inputs from the analog and driver side
  typedef struct packed {
    logic supply_disable_fault;
    logic pos_low_side_overcurrent;
    logic neg_low_side_overcurrent;
    logic pos_high_side_overcurrent;
    logic neg_high_side_overcurrent;
    logic thermal_fault;
    logic driver_clock_on;
    logic resonance_locked;
    logic converter_running;
    logic supply_undervoltage;
    logic vibration_timeout;
    logic tune_done;
  } hsif_cond_t;

  // whole block state
  typedef struct packed {
    hsif_cond_t sync1;
    hsif_cond_t sync2;
    logic [7:0] status0;
    logic summary_fault;
    logic converter_running;
    logic uvlo_q;
    logic timeout_q;
    logic tune_q;
    logic [7:0] fault_change_flags;
    logic [HSIF_EVENT_BITS-1:0] event_flags;
    logic [7:0] fault_change_mask;
    logic [HSIF_EVENT_BITS-1:0] event_mask;
    logic [7:0] rdata;
    logic irq;
    logic driver_lock;
    logic primed;
  } hsif_state_t;

endpackage

// >>> dv/tb_top.sv
// Purpose: self-checking bench for the haptic status and interrupt-flag block
// Assumes: bench drives conditions and the register port directly, fixed seed
// Notes: expectations come from bench functions; conditions held >= 4 clocks
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import hsif_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic i_clk = 1'b0; // 10 MHz clock
  logic i_sys_rst = 1'b1; // held high at start
  hsif_cond_t i_cond = '0; // raw conditions
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic o_irq;
  logic o_driver_lock;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] e_chg, e_cmsk, d; // expected change flags, mask, scratch
  logic [3:0] e_evt, e_emsk; // expected event flags and mask
  hsif_cond_t c_old, c_new;

  hsif_status_irq i_hsif_status_irq (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cond(i_cond), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_driver_lock(o_driver_lock));

  // clock: invert every half period
  always #50 i_clk = ~i_clk;

  // hang guard: counts a mismatch and closes the run
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // expectation functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] f_s0(input hsif_cond_t c);
    return {c.supply_disable_fault, c.pos_low_side_overcurrent, c.neg_low_side_overcurrent,
      c.pos_high_side_overcurrent, c.neg_high_side_overcurrent, c.thermal_fault,
      c.driver_clock_on, c.resonance_locked};
  endfunction
  function automatic logic f_sum(input hsif_cond_t c);
    logic [7:0] s;
    s = f_s0(c);
    return (|s[7:2]) | c.supply_undervoltage | c.vibration_timeout;
  endfunction

  // ----------------------------------------------------------------
  // compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares = compares + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // one-cycle read strobe; data sampled mid-way through the following cycle
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk_byte(o_rdata, exp);
  endtask
  // interrupt level after flag or mask updates have landed
  task automatic chk_irq();
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    chk_bit(o_irq, (|(e_chg & e_cmsk)) | (|(e_evt & e_emsk)));
  endtask
  task automatic final_report();
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(62));
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    {e_chg, e_cmsk, e_evt, e_emsk, c_old} = '0;
    // every index up to the clear registers reads zero after reset, unmapped too
    for (int a = 0; a < 18; a++) rd_chk(8'(a), 8'h00);
    chk_bit(o_irq, 1'b0);
    for (int n = 0; n < 40; n++) begin
      c_new = hsif_cond_t'(12'($urandom()));
      if (n % 5 == 4) c_new = '0; // corner: everything falls at once
      @(posedge i_clk);
      i_cond <= c_new;
      repeat (4) @(posedge i_clk);
      e_chg = e_chg | (f_s0(c_old) ^ f_s0(c_new));
      e_evt[0] = e_evt[0] | (f_sum(c_old) ^ f_sum(c_new));
      e_evt[1] = e_evt[1] | (c_new.supply_undervoltage & ~c_old.supply_undervoltage);
      e_evt[2] = e_evt[2] | (c_new.vibration_timeout & ~c_old.vibration_timeout);
      e_evt[3] = e_evt[3] | (c_new.tune_done & ~c_old.tune_done);
      rd_chk(HSIF_ADDR_DRIVER_FAULT_STATUS, f_s0(c_new));
      rd_chk(HSIF_ADDR_DRIVER_FAULT_STATUS, f_s0(c_new));
      rd_chk(HSIF_ADDR_SUMMARY_FAULT_STATUS, {7'h00, f_sum(c_new)});
      rd_chk(HSIF_ADDR_CONVERTER_BUSY_STATUS, {6'h00, c_new.converter_running, 1'b0});
      chk_bit(o_driver_lock, f_sum(c_new));
      // writes to read-only places must be ignored
      wr(HSIF_ADDR_FAULT_CHANGE_FLAGS, 8'hff);
      wr(HSIF_ADDR_EVENT_FLAGS, 8'hff);
      rd_chk(HSIF_ADDR_FAULT_CHANGE_FLAGS, e_chg);
      rd_chk(HSIF_ADDR_EVENT_FLAGS, {4'h0, e_evt});
      e_cmsk = 8'($urandom());
      d = 8'($urandom());
      e_emsk = d[3:0];
      wr(HSIF_ADDR_FAULT_CHANGE_MASK, e_cmsk);
      wr(HSIF_ADDR_EVENT_MASK, d);
      rd_chk(HSIF_ADDR_FAULT_CHANGE_MASK, e_cmsk);
      rd_chk(HSIF_ADDR_EVENT_MASK, {4'h0, e_emsk});
      chk_irq();
      if (n % 3 == 0 || n == 39) begin
        // write-one clears; the last pass wipes everything
        d = (n == 39) ? 8'hff : 8'($urandom());
        wr(HSIF_ADDR_FAULT_CHANGE_CLEAR, d);
        e_chg = e_chg & ~d;
        d = (n == 39) ? 8'hff : 8'($urandom());
        wr(HSIF_ADDR_EVENT_CLEAR, d);
        e_evt = e_evt & ~d[3:0];
        rd_chk(HSIF_ADDR_FAULT_CHANGE_FLAGS, e_chg);
        chk_irq();
      end
      c_old = c_new;
    end
    // second reset in mid-run with conditions raised beforehand
    @(posedge i_clk);
    i_cond <= '1;
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b1;
    i_cond <= '0;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (3) @(posedge i_clk);
    rd_chk(HSIF_ADDR_FAULT_CHANGE_FLAGS, 8'h00);
    rd_chk(HSIF_ADDR_EVENT_FLAGS, 8'h00);
    rd_chk(HSIF_ADDR_FAULT_CHANGE_MASK, 8'h00);
    chk_bit(o_irq, 1'b0);
    chk_bit(o_driver_lock, 1'b0);
    final_report();
  end
endmodule

`default_nettype wire
